// ==== core/tcc_consts.vh ====
// Purpose: constants of the four-channel capture/compare block
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes: included by tcc_channels.v and tcc_input_filter.v
//
// Function
// R1: Four independent channels, each capture or compare, each with its value register.
// R2: Capture loads counter into value register, sets flag, interrupt when enabled.
// R3: Input is own pin or XOR of pins 0-2, synchronised then filtered.
// R4: Rising or falling edge chosen by polarity bits; capture only when enabled.
// R5: Source select picks own, neighbour or trigger; nonzero locks value register.
// R6: Prescaler turns several detected edges into one capture event.
// R7: Capture while flag already set also sets the over-capture flag.
// R8: Capture interrupt needs interrupt enable, capture DMA needs DMA enable.
// R9: Writing generate bit makes the channel event without any input edge.
// R10: Select 01 routes own input, 10 routes the neighbour channel's input.
// R11: Below mode 1100 the combined prepare equals the channel's own prepare.
// R12: Modes 1100/1101 combine own and partner prepare by OR or AND.
// R13: Modes 1110/1111 pick own or partner prepare by count direction.
// R14: Pin level is combined prepare through polarity, driven only when enabled.
// R15: Counter equal to value register sets, clears or toggles prepare by mode.
// R16: Compare match sets flag, interrupt if enabled, DMA if compare DMA enabled.
// R17: Shadow enable chooses buffered or direct compare value writes.
// R18: Software may rewrite compare values while the counter runs.
// R19: Mode 110 is PWM mode 0, 111 is PWM mode 1.
// R20: Edge-aligned PWM: period from reload, duty from compare value.
// R21: Center-aligned PWM: period twice reload, duty twice compare value.
// R22: Up counting with compare above reload: PWM0 inactive, PWM1 active forever.
// R23: Modes 0-3 keep, set, clear, toggle on match; 4/5 force low/high.
// R24: Combined mode 0 gives OR, combined mode 1 gives AND.
// R25: Asymmetric: own value shapes up counting, partner value shapes down counting.
// R26: Shadowed value moves to the active register at the next update event.
// R27: Flags stay set until software clears; new capture overwrites the value.
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH

// Register map, byte addresses
`define TCC_CFG0_ADR 8'h00
`define TCC_VAL0_ADR 8'h10
`define TCC_STATUS_ADR 8'h20
`define TCC_SWGEN_ADR 8'h24
`define TCC_STATE_ADR 8'h28
`define TCC_GLOBAL_ADR 8'h2c

// Channel configuration fields
`define TCC_F_MODE 0
`define TCC_F_SRC 4
`define TCC_F_FLT 6
`define TCC_F_PSC 10
`define TCC_F_POL 12
`define TCC_F_NPOL 13
`define TCC_F_CAPEN 14
`define TCC_F_SHADOW 15
`define TCC_F_IRQEN 16
`define TCC_F_CDMA 17
`define TCC_F_CMPDMA 18
`define TCC_F_OE 19
`define TCC_CFG_W 20
`define TCC_CFG_RST 20'h00000

// Source select codes
`define TCC_SRC_OUT 2'h0
`define TCC_SRC_OWN 2'h1
`define TCC_SRC_NBR 2'h2
`define TCC_SRC_TRG 2'h3

// Compare mode codes
`define TCC_M_KEEP 4'h0
`define TCC_M_SET 4'h1
`define TCC_M_CLR 4'h2
`define TCC_M_TOG 4'h3
`define TCC_M_LOW 4'h4
`define TCC_M_HIGH 4'h5
`define TCC_M_PWM0 4'h6
`define TCC_M_PWM1 4'h7
`define TCC_M_COMB0 4'hc
`define TCC_M_COMB1 4'hd
`define TCC_M_ASYM0 4'he
`define TCC_M_ASYM1 4'hf

`endif

// ==== core/tcc_input_filter.v ====
// Purpose: synchroniser and digital filter of one channel input
// Assumes: filter_sel gives the number of equal samples needed, 0 bypasses
// Notes: output updates only after the input has been stable long enough
`timescale 1ns/1ps
`include "tcc_consts.vh"

module tcc_input_filter #(
  parameter FW = 4
) (
  input wire clk,
  input wire rst_b,
  input wire raw_in,
  input wire [FW-1:0] filter_sel,
  output reg filt_out
);

  reg sync1_ff;
  reg sync2_ff;
  reg last_ff;
  reg [FW-1:0] cnt_ff;
  reg [FW-1:0] nxt_cnt;
  reg nxt_filt;

  // --------------------------------------------------------------
  // Synchroniser
  // --------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= raw_in; // R3
      sync2_ff <= sync1_ff;
    end
  end

  // --------------------------------------------------------------
  // Filter
  // --------------------------------------------------------------
  always @* begin
    nxt_cnt = cnt_ff;
    nxt_filt = filt_out;
    if (filter_sel == {FW{1'b0}}) begin
      nxt_filt = sync2_ff;
      nxt_cnt = {FW{1'b0}};
    end else if (sync2_ff != last_ff) begin
      nxt_cnt = {FW{1'b0}};
    end else if (cnt_ff + 1'b1 >= filter_sel) begin // R3
      nxt_filt = sync2_ff;
    end else begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_ff <= 1'b0;
      cnt_ff <= {FW{1'b0}};
      filt_out <= 1'b0;
    end else begin
      last_ff <= sync2_ff;
      cnt_ff <= nxt_cnt;
      filt_out <= nxt_filt;
    end
  end

endmodule

// ==== core/tcc_channels.v ====
// Purpose: four capture/compare channels of a 16-bit timer, Wishbone slave
// Assumes: counter value, direction and update event come from the counter unit
// Notes: one-cycle Wishbone ack; unmapped reads return zero
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "tcc_consts.vh"

module tcc_channels #(
  parameter CW = 16,
  parameter NCH = 4
) (
  input wire clk,
  input wire rst_b,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [CW-1:0] counter_value,
  input wire count_down,
  input wire update_event,
  input wire [CW-1:0] reload_value,
  input wire internal_trigger,
  input wire [NCH-1:0] chan_input,
  output reg [NCH-1:0] chan_out_pin,
  output reg [NCH-1:0] chan_out_oe,
  output reg [NCH-1:0] chan_irq,
  output reg [NCH-1:0] chan_dma_req
);

  // --------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i;
  wire wr_status = bus_wr & (wb_adr_i == `TCC_STATUS_ADR) & wb_sel_i[0];
  wire wr_swgen = bus_wr & (wb_adr_i == `TCC_SWGEN_ADR) & wb_sel_i[0];
  wire wr_global = bus_wr & (wb_adr_i == `TCC_GLOBAL_ADR) & wb_sel_i[0];

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[8*i +: 8] = new_v[8*i +: 8];
        end
      end
    end
  endfunction

  reg [`TCC_CFG_W-1:0] cfg_ff [0:NCH-1];
  reg [CW-1:0] val_ff [0:NCH-1];
  reg [CW-1:0] shadow_ff [0:NCH-1];
  reg [NCH-1:0] flag_ff;
  reg [NCH-1:0] ovf_ff;
  reg [NCH-1:0] prep_ff;
  reg xor_sel_ff;
  wire [NCH-1:0] filt;
  wire [NCH-1:0] comb;

  // --------------------------------------------------------------
  // Global control
  // --------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xor_sel_ff <= 1'b0;
    end else if (wr_global) begin
      xor_sel_ff <= wb_dat_i[0];
    end
  end

  // --------------------------------------------------------------
  // Channels
  // --------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch // R1
      wire [`TCC_CFG_W-1:0] cfg = cfg_ff[g];
      wire [3:0] mode = cfg[`TCC_F_MODE +: 4];
      wire [1:0] src = cfg[`TCC_F_SRC +: 2];
      wire [1:0] psc = cfg[`TCC_F_PSC +: 2];
      wire pol = cfg[`TCC_F_POL];
      wire npol = cfg[`TCC_F_NPOL];
      wire in_mode = (src != `TCC_SRC_OUT);
      // Sums are 32 bits wide; only the low byte is an address
      wire [31:0] cfg_sum = `TCC_CFG0_ADR + 4 * g;
      wire [31:0] val_sum = `TCC_VAL0_ADR + 4 * g;
      wire [7:0] cfg_adr = cfg_sum[7:0];
      wire [7:0] val_adr = val_sum[7:0];
      wire wr_cfg = bus_wr & (wb_adr_i == cfg_adr);
      wire wr_val = bus_wr & (wb_adr_i == val_adr) & ~in_mode; // R5
      wire [31:0] cfg_new = merge({{(32-`TCC_CFG_W){1'b0}}, cfg}, wb_dat_i, wb_sel_i);
      wire [31:0] val_new = merge({{(32-CW){1'b0}}, val_ff[g]}, wb_dat_i, wb_sel_i);
      wire raw;
      wire sel_lvl;
      reg prev_ff;
      reg [2:0] psc_cnt_ff;
      reg eq_ff;

      // Only channel 0 gets the XOR of pins 0-2, for hall-style sensing
      if (g == 0) begin : g_xor
        assign raw = xor_sel_ff ? ^chan_input[2:0] : chan_input[0]; // R3
      end else begin : g_own
        assign raw = chan_input[g];
      end

      tcc_input_filter #(.FW(4)) u_filt (
        .clk(clk),
        .rst_b(rst_b),
        .raw_in(raw),
        .filter_sel(cfg[`TCC_F_FLT +: 4]),
        .filt_out(filt[g])
      );

      // R10
      assign sel_lvl = (src == `TCC_SRC_OWN) ? filt[g] :
                       (src == `TCC_SRC_NBR) ? filt[g ^ 1] : internal_trigger; // R5

      wire rise = sel_lvl & ~prev_ff;
      wire fall = ~sel_lvl & prev_ff;
      // Both bits set selects both edges
      wire edge_hit = (pol & npol) ? (rise | fall) : (pol ? fall : rise); // R4
      wire cap_act = cfg[`TCC_F_CAPEN] & in_mode; // R4
      wire [2:0] psc_lim = (3'h1 << psc) - 3'h1;
      wire cap_pulse = cap_act & edge_hit & (psc_cnt_ff == psc_lim); // R6
      wire sg = wr_swgen & wb_dat_i[g]; // R9
      wire capture = cap_pulse | (sg & in_mode);
      wire eq = (counter_value == val_ff[g]);
      // Edge of equality so a stopped counter does not re-fire
      wire match = ~in_mode & eq & ~eq_ff; // R15
      wire event_hit = capture | match | sg;
      wire clr_flag = wr_status & wb_dat_i[g];
      wire clr_ovf = wr_status & wb_dat_i[4 + g];
      wire nxt_flag = event_hit | (flag_ff[g] & ~clr_flag); // R27
      wire nxt_ovf = (capture & flag_ff[g]) | (ovf_ff[g] & ~clr_ovf); // R7
      wire dma_hit = (capture & cfg[`TCC_F_CDMA]) | // R8
                     (match & cfg[`TCC_F_CMPDMA]) | // R16
                     (sg & ~in_mode & cfg[`TCC_F_CMPDMA]); // R9
      // Above reload in up counting the level never leaves inactive
      wire pwm0 = count_down ? (counter_value <= val_ff[g]) : // R21
                  ((val_ff[g] > reload_value) ? 1'b0 : (counter_value < val_ff[g])); // R22
      reg nxt_prep;

      always @* begin
        nxt_prep = prep_ff[g];
        case (mode)
          `TCC_M_KEEP: nxt_prep = prep_ff[g]; // R23
          `TCC_M_SET: nxt_prep = match ? 1'b1 : prep_ff[g]; // R15
          `TCC_M_CLR: nxt_prep = match ? 1'b0 : prep_ff[g]; // R15
          `TCC_M_TOG: nxt_prep = match ? ~prep_ff[g] : prep_ff[g]; // R15
          `TCC_M_LOW: nxt_prep = 1'b0; // R23
          `TCC_M_HIGH: nxt_prep = 1'b1; // R23
          `TCC_M_PWM0: nxt_prep = pwm0; // R19 R20
          `TCC_M_PWM1: nxt_prep = ~pwm0; // R19
          `TCC_M_COMB0: nxt_prep = pwm0;
          `TCC_M_COMB1: nxt_prep = ~pwm0;
          `TCC_M_ASYM0: nxt_prep = pwm0;
          `TCC_M_ASYM1: nxt_prep = ~pwm0;
          default: nxt_prep = prep_ff[g];
        endcase
        if (in_mode) begin
          nxt_prep = 1'b0;
        end
      end

      // R11 R12 R13 R24 R25
      assign comb[g] = (mode == `TCC_M_COMB0) ? (prep_ff[g] | prep_ff[g ^ 1]) :
                       (mode == `TCC_M_COMB1) ? (prep_ff[g] & prep_ff[g ^ 1]) :
                       (mode[3:1] == 3'b111) ? (count_down ? prep_ff[g ^ 1] : prep_ff[g]) :
                       prep_ff[g];

      // --------------------------------------------------------------
      // Channel configuration
      // --------------------------------------------------------------
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          cfg_ff[g] <= `TCC_CFG_RST;
        end else if (wr_cfg) begin
          cfg_ff[g] <= cfg_new[`TCC_CFG_W-1:0];
        end
      end

      // --------------------------------------------------------------
      // Value and shadow registers
      // --------------------------------------------------------------
      // Capture beats a direct write, which beats the shadow load
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          val_ff[g] <= {CW{1'b0}};
        end else if (capture) begin
          val_ff[g] <= counter_value; // R2 R27
        end else if (wr_val && !cfg[`TCC_F_SHADOW]) begin
          val_ff[g] <= val_new[CW-1:0]; // R17 R18
        end else if (update_event && cfg[`TCC_F_SHADOW]) begin
          val_ff[g] <= shadow_ff[g]; // R26
        end
      end

      // Shadow always follows writes, so enabling it later is safe
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          shadow_ff[g] <= {CW{1'b0}};
        end else if (wr_val) begin
          shadow_ff[g] <= val_new[CW-1:0]; // R17
        end
      end

      // --------------------------------------------------------------
      // Flags
      // --------------------------------------------------------------
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          flag_ff[g] <= 1'b0;
          ovf_ff[g] <= 1'b0;
        end else begin
          flag_ff[g] <= nxt_flag; // R2 R16
          ovf_ff[g] <= nxt_ovf;
        end
      end

      // --------------------------------------------------------------
      // Prepare signal and match history
      // --------------------------------------------------------------
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          prep_ff[g] <= 1'b0;
          eq_ff <= 1'b0;
        end else begin
          prep_ff[g] <= nxt_prep;
          eq_ff <= eq;
        end
      end

      // --------------------------------------------------------------
      // Input edge history and prescaler
      // --------------------------------------------------------------
      // Counter clears while capture is off so a restart begins fresh
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          prev_ff <= 1'b0;
          psc_cnt_ff <= 3'h0;
        end else begin
          prev_ff <= sel_lvl;
          if (!cap_act) begin
            psc_cnt_ff <= 3'h0;
          end else if (edge_hit) begin
            psc_cnt_ff <= cap_pulse ? 3'h0 : psc_cnt_ff + 3'h1; // R6
          end
        end
      end

      // --------------------------------------------------------------
      // Registered outputs
      // --------------------------------------------------------------
      // Pin is gated by the enable so a disabled pin never shows high
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          chan_out_pin[g] <= 1'b0;
          chan_out_oe[g] <= 1'b0;
          chan_irq[g] <= 1'b0;
          chan_dma_req[g] <= 1'b0;
        end else begin
          chan_out_pin[g] <= cfg[`TCC_F_OE] & (comb[g] ^ pol); // R14
          chan_out_oe[g] <= cfg[`TCC_F_OE]; // R14
          chan_irq[g] <= nxt_flag & cfg[`TCC_F_IRQEN]; // R2 R8 R16
          chan_dma_req[g] <= dma_hit;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------
  // Read mux and ack
  // --------------------------------------------------------------
  reg [31:0] nxt_rd;
  integer k;

  always @* begin
    nxt_rd = 32'h00000000;
    for (k = 0; k < NCH; k = k + 1) begin
      if (wb_adr_i == `TCC_CFG0_ADR + 4 * k) begin
        nxt_rd = {{(32-`TCC_CFG_W){1'b0}}, cfg_ff[k]};
      end
      if (wb_adr_i == `TCC_VAL0_ADR + 4 * k) begin
        nxt_rd = {{(32-CW){1'b0}}, val_ff[k]};
      end
    end
    case (wb_adr_i)
      `TCC_STATUS_ADR: nxt_rd = {24'h000000, ovf_ff, flag_ff};
      `TCC_STATE_ADR: nxt_rd = {24'h000000, comb, prep_ff};
      `TCC_GLOBAL_ADR: nxt_rd = {31'h00000000, xor_sel_ff};
      default: nxt_rd = nxt_rd;
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req && !wb_we_i) ? nxt_rd : 32'h00000000;
    end
  end

endmodule

// ==== sim/tcc_channels_chk_sva.sv ====
// Purpose: port checks of the capture/compare block
// Assumes: one clock, rst_b async active low
// Notes: bound into tcc_channels
`timescale 1ns/1ps
module tcc_channels_chk #(
  parameter CW = 16,
  parameter NCH = 4
) (
  input wire clk,
  input wire rst_b,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [NCH-1:0] chan_out_pin,
  input wire [NCH-1:0] chan_out_oe,
  input wire [NCH-1:0] chan_irq,
  input wire [NCH-1:0] chan_dma_req
);
  // ----------
  // Checks
  // ----------
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  wire req = wb_cyc_i & wb_stb_i;
  wire wreq = req & wb_we_i;
  sequence s_req;
    req && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_follows_req: assert property (s_req |=> s_ack)
    else $error("ack not one cycle after request");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_pin_needs_oe: assert property ((chan_out_pin & ~chan_out_oe) == {NCH{1'b0}})
    else $error("pin high while not enabled");
  a_dma_single_pulse: assert property ((chan_dma_req & $past(chan_dma_req)) == {NCH{1'b0}})
    else $error("dma request longer than a pulse");
  a_quiet_after_reset: assert property ($rose(rst_b) |-> {chan_out_oe, chan_irq} == 8'h00)
    else $error("outputs active after reset");
  a_oe_needs_write: assert property (chan_out_oe != $past(chan_out_oe) |-> $past(wreq) || $past(wreq, 2))
    else $error("output enable moved without a write");
  a_irq_held_set: assert property ((($past(chan_irq) & ~chan_irq) != {NCH{1'b0}}) |-> $past(wreq) || $past(wreq, 2))
    else $error("interrupt dropped without a write");
endmodule

bind tcc_channels tcc_channels_chk #(.CW(CW), .NCH(NCH)) chk_u (
  .clk(clk),
  .rst_b(rst_b),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .chan_out_pin(chan_out_pin),
  .chan_out_oe(chan_out_oe),
  .chan_irq(chan_irq),
  .chan_dma_req(chan_dma_req)
);

// ==== sim/tcc_counter_model.sv ====
// Purpose: counter unit beside the channels
// Assumes: up counting, or up then down when center is high
// Notes: update_event is a one-cycle pulse at each turn
`timescale 1ns/1ps
module tcc_counter_model #(
  parameter CW = 16
) (
  input wire clk,
  input wire rst_b,
  input wire run,
  input wire center,
  input wire [CW-1:0] reload,
  output reg [CW-1:0] counter_value,
  output reg count_down,
  output reg update_event
);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      counter_value <= {CW{1'b0}};
      count_down <= 1'b0;
      update_event <= 1'b0;
    end else begin
      update_event <= 1'b0;
      if (run && !count_down) begin
        if (counter_value >= reload) begin
          update_event <= 1'b1;
          count_down <= center;
          counter_value <= center ? counter_value - 1'b1 : {CW{1'b0}};
        end else begin
          counter_value <= counter_value + 1'b1;
        end
      end else if (run) begin
        if (counter_value == {CW{1'b0}}) begin
          update_event <= 1'b1;
          count_down <= 1'b0;
          counter_value <= 1;
        end else begin
          counter_value <= counter_value - 1'b1;
        end
      end
    end
  end
endmodule

// ==== sim/test_tcc_channels.sv ====
// Purpose: self-checking bench of tcc_channels
// Assumes: one-cycle Wishbone ack, counter from the model
// Notes: pins driven by the bench, trigger and byte lanes tied
`timescale 1ns/1ps
`include "tcc_consts.vh"
module test_tcc_channels;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic run = 1'b0;
  logic center = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] q;
  logic [15:0] reload = 16'h0014;
  logic [15:0] cv;
  logic [3:0] pins = 4'h0;
  wire [15:0] cnt;
  wire cdown;
  wire upd;
  wire ack;
  wire [31:0] rd;
  wire [3:0] pin, oe, irq, dma;
  integer n_fail = 0;
  integer total_checks = 0;
  integer dma_hits = 0;
  integer i, d0;
  always #10 clk = ~clk;
  always @(posedge clk) dma_hits <= dma_hits + $countones(dma);
  tcc_counter_model ctr_u (.clk(clk), .rst_b(rst_b), .run(run), .center(center),
    .reload(reload), .counter_value(cnt), .count_down(cdown), .update_event(upd));
  tcc_channels dut_u (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rd),
    .wb_ack_o(ack), .counter_value(cnt), .count_down(cdown), .update_event(upd),
    .reload_value(reload), .internal_trigger(1'b0), .chan_input(pins),
    .chan_out_pin(pin), .chan_out_oe(oe), .chan_irq(irq), .chan_dma_req(dma));
  // ----------
  // Shared tasks
  // ----------
  task end_of_test;
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk(ack, 1);
    if (ack !== 1'b1) end_of_test;
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  task wait_irq(input integer ch);
    integer n;
    for (n = 0; n < 40 && irq[ch] !== 1'b1; n++) @(posedge clk);
    chk(irq[ch], 1);
  endtask
  task duty(input integer ch, input integer len, input integer exp);
    integer h, k;
    h = 0;
    repeat (90) @(posedge clk);
    for (k = 0; k < len; k++) begin
      @(posedge clk);
      h = h + pin[ch];
    end
    chk(h, exp);
  endtask
  // ----------
  // Scenarios
  // ----------
  task t_regs;
    wb(0, `TCC_CFG0_ADR, 0);
    chk(q, 0);
    wb(1, 8'h3c, 32'hffff);
    wb(0, 8'h3c, 0);
    chk(q, 0);
    for (i = 0; i < 4; i++) wb(1, 8'h10 + 4 * i, 16'h00a5 + i);
    for (i = 0; i < 4; i++) begin
      wb(0, 8'h10 + 4 * i, 0);
      chk(q, 16'h00a5 + i);
    end
  endtask
  task t_capture;
    wb(1, `TCC_STATUS_ADR, 32'hff);
    wb(1, 8'h04, 32'h34010);
    wb(1, 8'h00, 32'h04020);
    run <= 1'b1;
    repeat (7) @(posedge clk);
    run <= 1'b0;
    repeat (2) @(posedge clk);
    cv = cnt;
    d0 = dma_hits;
    pins[1] <= 1'b1;
    wait_irq(1);
    wb(0, 8'h14, 0);
    chk(q, cv);
    pins[1] <= 1'b0;
    repeat (8) @(posedge clk);
    pins[1] <= 1'b1;
    repeat (12) @(posedge clk);
    chk(dma_hits - d0, 2);
    wb(0, `TCC_STATUS_ADR, 0);
    chk(q, 32'h33);
    wb(1, 8'h14, 32'hffff);
    wb(0, 8'h14, 0);
    chk(q, cv);
    wb(1, `TCC_STATUS_ADR, 32'h33);
    chk(irq, 0);
    wb(1, 8'h04, 0);
    wb(1, 8'h00, 0);
  endtask
  task t_swgen;
    wb(1, 8'h08, 32'h50000);
    d0 = dma_hits;
    wb(1, `TCC_SWGEN_ADR, 32'h4);
    wait_irq(2);
    chk(dma_hits - d0, 1);
    wb(1, `TCC_STATUS_ADR, 32'h4);
    wb(1, 8'h08, 0);
  endtask
  task t_cmp;
    logic [3:0] md [4] = '{4'h1, 4'h2, 4'h4, 4'h5};
    logic ex [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    run <= 1'b1;
    wb(1, 8'h1c, 5);
    for (i = 0; i < 4; i++) begin
      wb(1, 8'h0c, 32'h80000 | md[i]);
      repeat (50) @(posedge clk);
      chk(pin[3], ex[i]);
    end
    wb(1, 8'h0c, 32'h80003);
    repeat (50) @(posedge clk);
    d0 = pin[3];
    repeat (21) @(posedge clk);
    chk(pin[3], !d0);
    wb(0, `TCC_STATUS_ADR, 0);
    chk(q & 32'h8, 32'h8);
    wb(1, 8'h0c, 32'h81005);
    repeat (3) @(posedge clk);
    chk(pin[3], 0);
    wb(1, 8'h0c, 32'h5);
    repeat (3) @(posedge clk);
    chk({oe[3], pin[3]}, 0);
  endtask
  task t_pwm;
    logic [15:0] tv [4] = '{16'h8, 16'h8, 16'h1e, 16'h1e};
    integer te [4] = '{8, 13, 0, 21};
    for (i = 0; i < 4; i++) begin
      wb(1, 8'h1c, tv[i]);
      wb(1, 8'h0c, 32'h80006 + i % 2);
      duty(3, 21, te[i]);
    end
    center <= 1'b1;
    wb(1, 8'h1c, 8);
    wb(1, 8'h0c, 32'h80006);
    duty(3, 40, 16);
    wb(1, 8'h0c, 0);
  endtask
  task t_comb;
    wb(1, 8'h14, 10);
    wb(1, 8'h04, 32'h80006);
    wb(1, 8'h10, 4);
    wb(1, 8'h00, 32'h8000e);
    duty(0, 40, 14);
    center <= 1'b0;
    wb(1, 8'h00, 32'h80006);
    duty(0, 21, 4);
    wb(1, 8'h00, 32'h8000c);
    duty(0, 21, 10);
    wb(1, 8'h00, 32'h8000d);
    duty(0, 21, 6);
  endtask
  task t_input;
    run <= 1'b0;
    wb(1, 8'h04, 32'h54d0);
    wb(1, `TCC_STATUS_ADR, 32'hff);
    pins[1] <= 1'b0;
    @(posedge clk);
    pins[1] <= 1'b1;
    repeat (10) @(posedge clk);
    for (i = 0; i < 2; i++) begin
      pins[1] <= 1'b0;
      repeat (10) @(posedge clk);
      wb(0, `TCC_STATUS_ADR, 0);
      chk(q & 32'h2, i * 2);
      pins[1] <= 1'b1;
      repeat (10) @(posedge clk);
    end
    wb(1, 8'h08, 32'h8000);
    wb(1, 8'h18, 32'h33);
    wb(0, 8'h18, 0);
    chk(q, 32'ha7);
    run <= 1'b1;
    repeat (30) @(posedge clk);
    run <= 1'b0;
    repeat (2) @(posedge clk);
    wb(0, 8'h18, 0);
    chk(q, 32'h33);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs;
    t_capture;
    t_swgen;
    t_cmp;
    t_pwm;
    t_comb;
    t_input;
    end_of_test;
  end
endmodule
